// *** tsp_pkg.sv ***
// shared constants, timing counts and helpers for the serial temperature sensor port
package tsp_pkg;

	// ************************************
	// clocking
	// ************************************
	localparam int CLK_HZ = 25_000_000;
	localparam int CLK_NS = 40;

	// ************************************
	// frame layout
	// ************************************
	localparam int FRAME_BITS = 32;
	localparam int SEND_BITS = 16;
	localparam int DRIVEN_BITS = 14;
	localparam int CMD_BITS = 8;
	localparam logic [4:0] LAST_BIT_SEND = 5'h0f;
	localparam logic [4:0] LAST_BIT_FRAME = 5'h1f;
	localparam logic [4:0] DRIVEN_END = 5'h0e;
	localparam logic [3:0] CMD_FULL = 4'h8;

	// ************************************
	// commands, word fields, reset values
	// ************************************
	localparam logic [7:0] CMD_SHUTDOWN = 8'hff;
	localparam logic [7:0] CMD_CONVERT = 8'h00;
	localparam int TEMP_LSB_POS = 3;
	localparam int FIXED_ONE_POS = 2;
	// identification word: value is arbitrary
	localparam logic [15:0] ID_WORD = 16'ha55c;
	// code shown before the first conversion completes: value is arbitrary
	localparam logic [12:0] INVALID_TEMP = 13'h0aaa;

	// ************************************
	// timing
	// ************************************
	localparam int CONV_TIME_MS = 280;
	localparam int CONV_CYCLES = CLK_HZ / 1000 * CONV_TIME_MS;
	localparam int HOST_WAIT_MS = 250;
	localparam int HOST_WAIT_CYCLES = CLK_HZ / 1000 * HOST_WAIT_MS;
	localparam int SCLK_MIN_NS = 330;
	localparam int SCLK_HALF_CYCLES = (SCLK_MIN_NS / 2 + CLK_NS - 1) / CLK_NS;

	// sent word: temperature, fixed one, two undriven bits shown as zero
	function automatic logic [15:0] tsp_temp_word(input logic [12:0] t);
		tsp_temp_word = {t, 1'b1, 2'b00};
	endfunction

	// only codes of the form 2^n-1 are safe to send
	function automatic logic tsp_cmd_legal(input logic [7:0] c);
		tsp_cmd_legal = ((c & (c + 8'h01)) == 8'h00);
	endfunction

endpackage

// *** tsp_link_if.sv ***
// three-wire link between the host controller and the sensor port
`timescale 1ns/100ps
interface tsp_link_if;
	logic cs_n;
	logic serial_clock;
	logic host_sio_o;
	logic host_sio_oe;
	logic dev_sio_o;
	logic dev_sio_oe;
	logic sio;

	// resolved data wire, weak pull-up when nobody drives
	assign sio = dev_sio_oe ? dev_sio_o : (host_sio_oe ? host_sio_o : 1'b1);

	modport dev (
		input cs_n,
		input serial_clock,
		input sio,
		output dev_sio_o,
		output dev_sio_oe
	);

	modport host (
		output cs_n,
		output serial_clock,
		output host_sio_o,
		output host_sio_oe,
		input sio
	);
endinterface

// *** tsp_sync.sv ***
// two-flop level synchroniser
`timescale 1ns/100ps
module tsp_sync #(
	parameter logic RST_VAL = 1'b0
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// level in and out
	input wire logic d,
	output logic q
);
	logic meta_q;

	// first stage feeds only the second
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			meta_q <= RST_VAL;
			q <= RST_VAL;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule // tsp_sync

// *** tsp_sensor_dev.sv ***
// sensor end: serial port on the link clock, conversion control on clk
`timescale 1ns/100ps
module tsp_sensor_dev #(
	parameter int CONV_CYCLES = tsp_pkg::CONV_CYCLES
) (
	// core clock and reset
	input wire logic clk,
	input wire logic reset,
	// link to the host
	tsp_link_if.dev link,
	// converter side
	input wire logic [12:0] temp_sample,
	output logic conv_done,
	output logic shutdown,
	output logic [12:0] temp_result
);
	import tsp_pkg::*;

	localparam int CW = $clog2(CONV_CYCLES + 1);
	localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYCLES - 1);

	typedef enum logic [1:0] {
		CONV_IDLE,
		CONV_RUN,
		CONV_HOLD
	} tsp_conv_t;

	// ************************************
	// link domain
	// ************************************
	logic link_rst;
	logic [4:0] bit_cnt_q;
	logic chain_vld_q;
	logic chain_sd_q;
	logic [7:0] rx_q;
	logic [3:0] rx_cnt_q;
	logic [15:0] send_word;
	logic use_id;
	logic [15:0] tx_temp_q;
	logic shutdown_q;

	// select high holds the link logic at rest
	assign link_rst = reset | link.cs_n;

	// bit position advances on falling edges and wraps every 32 clocks
	always_ff @(negedge link.serial_clock or posedge link_rst) begin
		if (link_rst) begin
			bit_cnt_q <= 5'h00;
		end else begin
			bit_cnt_q <= bit_cnt_q + 5'h01;
		end
	end

	// a command completed mid-frame steers the next send phase
	always_ff @(negedge link.serial_clock or posedge link_rst) begin
		if (link_rst) begin
			chain_vld_q <= 1'b0;
			chain_sd_q <= 1'b0;
		end else if (bit_cnt_q == LAST_BIT_FRAME && rx_cnt_q == CMD_FULL) begin
			chain_vld_q <= 1'b1;
			chain_sd_q <= (rx_q == CMD_SHUTDOWN);
		end
	end

	// receive shift; not cleared by select so the core can decode it afterwards
	always_ff @(posedge link.serial_clock or posedge reset) begin
		if (reset) begin
			rx_q <= CMD_CONVERT;
			rx_cnt_q <= 4'h0;
		end else if (bit_cnt_q[4]) begin
			rx_q <= {rx_q[6:0], link.sio};
			if (rx_cnt_q != CMD_FULL) begin
				rx_cnt_q <= rx_cnt_q + 4'h1;
			end
		end else begin
			rx_cnt_q <= 4'h0;
		end
	end

	// identification replaces temperature while shut down
	assign use_id = chain_vld_q ? chain_sd_q : shutdown_q;
	assign send_word = use_id ? ID_WORD : tx_temp_q;

	// first bit appears with select low, no clock edge needed
	assign link.dev_sio_o = send_word[4'hf - bit_cnt_q[3:0]];
	// fourteen bits driven, then quiet through the receive phase
	assign link.dev_sio_oe = ~link.cs_n & ~bit_cnt_q[4] & (bit_cnt_q < DRIVEN_END);

	// ************************************
	// core domain
	// ************************************
	logic cs_n_s;
	logic cs_prev_q;
	logic cs_rise;
	logic conv_end;
	tsp_conv_t conv_q;
	logic [CW-1:0] conv_cnt_q;
	logic [12:0] result_q;

	tsp_sync #(
		.RST_VAL(1'b1)
	) u_cs_sync (
		.clk(clk),
		.reset(reset),
		.d(link.cs_n),
		.q(cs_n_s)
	);

	// end of frame seen in core time
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cs_prev_q <= 1'b1;
		end else begin
			cs_prev_q <= cs_n_s;
		end
	end
	assign cs_rise = cs_n_s & ~cs_prev_q;

	// link clock is idle once select is high, so the byte is stable here
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			shutdown_q <= 1'b0;
		end else if (cs_rise && rx_cnt_q == CMD_FULL) begin
			shutdown_q <= (rx_q == CMD_SHUTDOWN);
		end
	end

	assign conv_end = (conv_q == CONV_RUN) && (conv_cnt_q == CONV_LAST);

	// conversion sequencing; a read delays the reload and the start of the next conversion, not the result capture
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			conv_q <= CONV_RUN;
		end else begin
			case (conv_q)
				CONV_IDLE: begin
					if (!shutdown_q) begin
						conv_q <= CONV_RUN;
					end
				end
				CONV_RUN: begin
					if (shutdown_q) begin
						conv_q <= CONV_IDLE;
					end else if (conv_end && !cs_n_s) begin
						conv_q <= CONV_HOLD;
					end
				end
				CONV_HOLD: begin
					if (shutdown_q) begin
						conv_q <= CONV_IDLE;
					end else if (cs_n_s) begin
						conv_q <= CONV_RUN;
					end
				end
				default: begin
					conv_q <= CONV_IDLE;
				end
			endcase
		end
	end

	// conversion timer restarts whenever a new conversion begins
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			conv_cnt_q <= '0;
		end else if (conv_q != CONV_RUN || conv_end) begin
			conv_cnt_q <= '0;
		end else begin
			conv_cnt_q <= conv_cnt_q + CW'(1);
		end
	end

	// result capture on every conversion end; send-word reload only while select is high
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			result_q <= INVALID_TEMP;
			tx_temp_q <= tsp_temp_word(INVALID_TEMP);
			conv_done <= 1'b0;
		end else begin
			conv_done <= conv_end;
			if (conv_end) begin
				result_q <= temp_sample;
			end
			if (conv_end && cs_n_s) begin
				tx_temp_q <= tsp_temp_word(temp_sample);
			end else if (conv_q == CONV_HOLD && cs_n_s) begin
				tx_temp_q <= tsp_temp_word(result_q);
			end
		end
	end

	// user-side mirrors, registered
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			shutdown <= 1'b0;
			temp_result <= INVALID_TEMP;
		end else begin
			shutdown <= shutdown_q;
			temp_result <= result_q;
		end
	end
endmodule // tsp_sensor_dev

// *** tsp_host_ctl.sv ***
// host end: makes select and the serial clock, reads words, sends commands
`timescale 1ns/100ps
module tsp_host_ctl #(
	parameter int HALF = tsp_pkg::SCLK_HALF_CYCLES,
	parameter int WAIT_CYCLES = tsp_pkg::HOST_WAIT_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// link to the sensor
	tsp_link_if.host link,
	// user requests
	input wire logic start,
	input wire logic with_cmd,
	input wire logic keep_low,
	input wire logic [7:0] cmd,
	// user answers
	output logic busy,
	output logic cmd_err,
	output logic rd_valid,
	output logic [15:0] rd_word,
	output logic data_stale
);
	import tsp_pkg::*;

	localparam int HW = $clog2(HALF + 1);
	localparam int WW = $clog2(WAIT_CYCLES + 1);

	typedef enum logic [2:0] {
		H_IDLE,
		H_SETUP,
		H_HIGH,
		H_LOW,
		H_GAP
	} tsp_hst_t;

	tsp_hst_t state_q;
	tsp_hst_t state_d;
	logic [HW-1:0] half_q;
	logic half_end;
	logic [4:0] bit_q;
	logic [4:0] next_bit;
	logic [4:0] out_idx;
	logic last;
	logic with_q;
	logic hold_q;
	logic [7:0] cmd_q;
	logic [15:0] cmd_word;
	logic [15:0] rd_sh_q;
	logic [WW-1:0] wait_q;
	logic sio_s;
	logic cs_n_q;
	logic sclk_q;
	logic sio_o_q;
	logic sio_oe_q;
	logic accept;
	logic rise;
	logic fall;
	logic finish;

	tsp_sync #(
		.RST_VAL(1'b1)
	) u_sio_sync (
		.clk(clk),
		.reset(reset),
		.d(link.sio),
		.q(sio_s)
	);

	assign half_end = (half_q == HW'(HALF - 1));
	assign last = (bit_q == (with_q ? LAST_BIT_FRAME : LAST_BIT_SEND));
	assign next_bit = bit_q + 5'h01;
	assign out_idx = LAST_BIT_FRAME - next_bit;
	assign cmd_word = {8'h00, cmd_q};

	// illegal codes are refused before select ever drops
	always_comb begin
		state_d = state_q;
		case (state_q)
			H_IDLE: begin
				if (start && (!with_cmd || tsp_cmd_legal(cmd))) begin
					state_d = H_SETUP;
				end
			end
			H_SETUP, H_LOW: begin
				if (half_end) begin
					state_d = H_HIGH;
				end
			end
			H_HIGH: begin
				if (half_end) begin
					state_d = !last ? H_LOW : (hold_q ? H_IDLE : H_GAP);
				end
			end
			H_GAP: begin
				if (half_end) begin
					state_d = H_IDLE;
				end
			end
			default: begin
				state_d = H_IDLE;
			end
		endcase
	end

	assign accept = (state_q == H_IDLE) && (state_d == H_SETUP);
	assign rise = (state_q != H_HIGH) && (state_d == H_HIGH);
	assign fall = (state_q == H_HIGH) && (state_d == H_LOW);
	assign finish = (state_q == H_HIGH) && (state_d != H_HIGH) && (state_d != H_LOW);

	// sequencer and half-period timer
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_q <= H_IDLE;
			half_q <= '0;
		end else begin
			state_q <= state_d;
			half_q <= (state_d != state_q) ? '0 : half_q + HW'(1);
		end
	end

	// pins; select only falls while the clock rests low
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cs_n_q <= 1'b1;
			sclk_q <= 1'b0;
		end else begin
			sclk_q <= (state_d == H_HIGH);
			if (accept) begin
				cs_n_q <= 1'b0;
			end else if (finish && !hold_q) begin
				cs_n_q <= 1'b1;
			end
		end
	end

	// request capture; chaining only makes sense on full frames
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			with_q <= 1'b0;
			hold_q <= 1'b0;
			cmd_q <= CMD_CONVERT;
			bit_q <= 5'h00;
		end else if (accept) begin
			with_q <= with_cmd;
			hold_q <= keep_low & with_cmd;
			cmd_q <= cmd;
			bit_q <= 5'h00;
		end else if (fall) begin
			bit_q <= next_bit;
		end
	end

	// sample on own rising edge, drive command on own falling edge
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rd_sh_q <= 16'h0000;
			sio_o_q <= 1'b0;
			sio_oe_q <= 1'b0;
		end else begin
			if (rise && !bit_q[4]) begin
				rd_sh_q <= {rd_sh_q[14:0], sio_s};
			end
			if (fall) begin
				sio_oe_q <= next_bit[4];
				sio_o_q <= cmd_word[out_idx[3:0]];
			end else if (accept || finish) begin
				sio_oe_q <= 1'b0;
			end
		end
	end

	// user answers
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			busy <= 1'b0;
			cmd_err <= 1'b0;
			rd_valid <= 1'b0;
			rd_word <= 16'h0000;
		end else begin
			busy <= (state_d != H_IDLE);
			cmd_err <= (state_q == H_IDLE) && start && with_cmd && !tsp_cmd_legal(cmd);
			rd_valid <= finish;
			if (finish) begin
				rd_word <= rd_sh_q;
			end
		end
	end

	// reads are flagged stale after power-up and after every command frame that ends with select released
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wait_q <= WW'(WAIT_CYCLES);
			data_stale <= 1'b1;
		end else begin
			if (finish && with_q && !hold_q) begin
				wait_q <= WW'(WAIT_CYCLES);
			end else if (wait_q != '0) begin
				wait_q <= wait_q - WW'(1);
			end
			data_stale <= (wait_q != '0);
		end
	end

	assign link.cs_n = cs_n_q;
	assign link.serial_clock = sclk_q;
	assign link.host_sio_o = sio_o_q;
	assign link.host_sio_oe = sio_oe_q;
endmodule // tsp_host_ctl

// *** tsp_link_properties.sv ***
// assertions on the link between host and sensor
`timescale 1ns/100ps
module tsp_link_properties (
	// core clock and reset
	input wire logic clk,
	input wire logic reset,
	// link signals
	input wire logic cs_n,
	input wire logic serial_clock,
	input wire logic host_sio_o,
	input wire logic host_sio_oe,
	input wire logic dev_sio_o,
	input wire logic dev_sio_oe,
	input wire logic sio
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	logic [4:0] fall_cnt_q;

	// falling link edges in a frame, wraps mod 32 like the sensor count
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			fall_cnt_q <= 5'h00;
		else if (cs_n)
			fall_cnt_q <= 5'h00;
		else if ($fell(serial_clock))
			fall_cnt_q <= fall_cnt_q + 5'h01;
	end

	// ****
	// checks
	// ****
	a_idle_released: assert property (cs_n |-> !dev_sio_oe)
		else $error("sensor drives data while deselected");
	// resolved wire rests at the pull-up level between frames
	a_idle_pullup: assert property (cs_n |-> sio)
		else $error("data wire not at rest level while deselected");
	a_select_start: assert property ($fell(cs_n) |-> dev_sio_oe && !serial_clock)
		else $error("bad frame start");
	// counter lags the fall by a cycle, so skip that sample
	a_drive_window: assert property (!cs_n && !$fell(serial_clock) |->
		dev_sio_oe == (fall_cnt_q < 5'h0e))
		else $error("sensor drive window wrong");
	a_out_on_fall: assert property (!cs_n && !$past(cs_n) && dev_sio_oe && $past(dev_sio_oe)
		&& $changed(dev_sio_o) |-> $fell(serial_clock))
		else $error("sensor data moved off the falling edge");
	a_host_talk_late: assert property ($rose(host_sio_oe) |->
		$fell(serial_clock) && fall_cnt_q == 5'h0f)
		else $error("host drove before the receive phase");
	a_host_data_hold: assert property (host_sio_oe && $past(host_sio_oe) && $changed(host_sio_o)
		|-> $fell(serial_clock))
		else $error("host data moved off the falling edge");
	a_no_clash: assert property (!(dev_sio_oe && host_sio_oe))
		else $error("both ends drive data");
	a_host_quiet: assert property (cs_n |-> !host_sio_oe)
		else $error("host drives data while deselected");

	// main scenarios seen
	c_frame: cover property ($fell(cs_n));
	c_receive: cover property ($rose(host_sio_oe));
	c_chain: cover property (!cs_n && fall_cnt_q == 5'h1f && $fell(serial_clock));
endmodule // tsp_link_properties

// *** tsp_port_bench.sv ***
// self-checking bench: host controller facing the sensor port
`timescale 1ns/100ps
module tsp_port_bench;
	import tsp_pkg::*;

	localparam logic [12:0] TEMP_A = 13'h1e48;
	localparam logic [12:0] TEMP_B = 13'h0191;
	localparam logic [15:0] ID_EXP = {ID_WORD[15:2], 2'b11};

	logic clk = 1'b0;
	logic reset = 1'b1;
	logic start = 1'b0;
	logic with_cmd = 1'b0;
	logic keep_low = 1'b0;
	logic [7:0] cmd = 8'h00;
	logic [12:0] temp_sample = TEMP_A;
	logic conv_done, shutdown, busy, cmd_err, rd_valid, data_stale;
	logic [12:0] temp_result;
	logic [15:0] rd_word, word_q;
	logic sd_end_q;
	int num_errors = 0;
	int n_checks = 0;

	tsp_link_if tsp_link_if_inst ();
	tsp_sensor_dev #(.CONV_CYCLES(200)) tsp_sensor_dev_inst (.clk(clk), .reset(reset),
		.link(tsp_link_if_inst), .temp_sample(temp_sample), .conv_done(conv_done),
		.shutdown(shutdown), .temp_result(temp_result));
	tsp_host_ctl #(.HALF(5), .WAIT_CYCLES(150)) tsp_host_ctl_inst (.clk(clk), .reset(reset),
		.link(tsp_link_if_inst), .start(start), .with_cmd(with_cmd), .keep_low(keep_low), .cmd(cmd),
		.busy(busy), .cmd_err(cmd_err), .rd_valid(rd_valid), .rd_word(rd_word), .data_stale(data_stale));
	tsp_link_properties tsp_link_properties_inst (.clk(clk), .reset(reset),
		.cs_n(tsp_link_if_inst.cs_n), .serial_clock(tsp_link_if_inst.serial_clock),
		.host_sio_o(tsp_link_if_inst.host_sio_o), .host_sio_oe(tsp_link_if_inst.host_sio_oe),
		.dev_sio_o(tsp_link_if_inst.dev_sio_o), .dev_sio_oe(tsp_link_if_inst.dev_sio_oe),
		.sio(tsp_link_if_inst.sio));

	// 25 MHz core clock
	always #20 clk = ~clk;

	// ****
	// shared tasks
	// ****
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
			num_errors++;
		end
	endtask

	task automatic close_out();
		$display("errors %0d checks %0d", num_errors, n_checks);
		if (num_errors == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// bounded wait: 0 rd_valid, 1 busy, 2 conv_done, 3 data_stale
	task automatic wait_sig(input int k, input logic lvl);
		int n = 0;
		logic v = 1'bx;
		do begin
			@(negedge clk);
			v = (k == 0) ? rd_valid : (k == 1) ? busy : (k == 2) ? conv_done : data_stale;
			n++;
		end while (v !== lvl && n < 1000);
		chk({15'h0000, v}, {15'h0000, lvl});
	endtask

	// one host frame; word and mode captured at the frame end
	task automatic frame(input logic wc, input logic kl, input logic [7:0] c);
		@(posedge clk);
		start <= 1'b1;
		with_cmd <= wc;
		keep_low <= kl;
		cmd <= c;
		@(posedge clk);
		start <= 1'b0;
		wait_sig(0, 1'b1);
		word_q = rd_word;
		sd_end_q = shutdown;
		wait_sig(1, 1'b0);
	endtask

	// bits 1:0 float and read high through the pull-up
	function automatic logic [15:0] tword(input logic [12:0] t);
		return {t, 1'b1, 2'b11};
	endfunction

	// ****
	// scenarios
	// ****
	task automatic t_power_up();
		chk({3'h0, temp_result}, {3'h0, INVALID_TEMP});
		chk({15'h0000, shutdown}, 16'h0000);
		frame(1'b0, 1'b0, 8'h00);
		chk(word_q, tword(INVALID_TEMP));
	endtask

	task automatic t_read_live();
		wait_sig(2, 1'b1);
		// result mirror trails the done pulse by one cycle
		@(negedge clk);
		chk({3'h0, temp_result}, {3'h0, TEMP_A});
		frame(1'b0, 1'b0, 8'h00);
		chk(word_q, tword(TEMP_A));
	endtask

	// a conversion ends mid-frame: old word now, new word next frame
	task automatic t_conv_in_frame();
		wait_sig(2, 1'b1);
		@(posedge clk);
		temp_sample <= TEMP_B;
		repeat (80) @(posedge clk);
		frame(1'b0, 1'b0, 8'h00);
		chk(word_q, tword(TEMP_A));
		frame(1'b0, 1'b0, 8'h00);
		chk(word_q, tword(TEMP_B));
	endtask

	task automatic t_shutdown();
		frame(1'b1, 1'b0, 8'hff);
		chk({15'h0000, sd_end_q}, 16'h0000);
		chk({15'h0000, shutdown}, 16'h0001);
		chk({15'h0000, data_stale}, 16'h0001);
		// send-only frame: select rises with no command received
		frame(1'b0, 1'b0, 8'h00);
		chk(word_q, ID_EXP);
		chk({15'h0000, shutdown}, 16'h0001);
	endtask

	// every other legal code leaves shutdown
	task automatic t_codes();
		logic [7:0] codes [8] = '{8'h01, 8'h03, 8'h07, 8'h0f, 8'h1f, 8'h3f, 8'h7f, 8'h00};
		foreach (codes[i]) begin
			frame(1'b1, 1'b0, 8'hff);
			chk({15'h0000, shutdown}, 16'h0001);
			frame(1'b1, 1'b0, codes[i]);
			chk({15'h0000, shutdown}, 16'h0000);
		end
	endtask

	// an unsafe code never reaches the wire
	task automatic t_refuse();
		logic seen = 1'b0;
		logic idle = 1'b1;
		@(posedge clk);
		start <= 1'b1;
		with_cmd <= 1'b1;
		cmd <= 8'h05;
		@(posedge clk);
		start <= 1'b0;
		repeat (3) begin
			@(negedge clk);
			seen = seen | cmd_err;
			idle = idle & tsp_link_if_inst.cs_n;
		end
		chk({15'h0000, seen}, 16'h0001);
		chk({15'h0000, idle}, 16'h0001);
	endtask

	// read, shut down, read the id, resume, all with select low
	task automatic t_chain();
		wait_sig(2, 1'b1);
		frame(1'b1, 1'b1, 8'hff);
		chk(word_q, tword(TEMP_B));
		frame(1'b1, 1'b0, 8'h00);
		chk(word_q, ID_EXP);
		chk({15'h0000, shutdown}, 16'h0000);
		repeat (140) @(negedge clk);
		chk({15'h0000, data_stale}, 16'h0001);
		wait_sig(3, 1'b0);
	endtask

	// main sequence
	initial begin
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		t_power_up();
		t_read_live();
		t_conv_in_frame();
		t_shutdown();
		t_refuse();
		t_codes();
		t_chain();
		close_out();
	end

	// watchdog well past the expected eight thousand cycles
	initial begin
		repeat (60000) @(posedge clk);
		num_errors++;
		close_out();
	end
endmodule // tsp_port_bench
